// *** rtl/ssc_defines.vh ***
`ifndef SSC_DEFINES_VH
`define SSC_DEFINES_VH
// register addresses on the plain register port
`define SSC_ADDR_W          12
`define SSC_ADDR_STATUS     12'h18F
`define SSC_ADDR_CTRL1      12'h190
`define SSC_ADDR_DATA       12'h193
`define SSC_ADDR_INT_STAT   12'h194
`define SSC_ADDR_INT_MASK   12'h195
// status register fields
`define SSC_ST_SMP          7
`define SSC_ST_CKE          6
`define SSC_ST_DA           5
`define SSC_ST_STOP         4
`define SSC_ST_START        3
`define SSC_ST_RW           2
`define SSC_ST_UA           1
`define SSC_ST_BF           0
// control one fields
`define SSC_C1_WRITE_COLLISION_FLAG         7
`define SSC_C1_OVF          6
`define SSC_C1_EN           5
`define SSC_C1_CKP          4
`define SSC_C1_MODE_HI      3
`define SSC_C1_MODE_LO      0
// interrupt status / mask fields
`define SSC_IRQ_BYTE        0
`define SSC_IRQ_START       1
`define SSC_IRQ_STOP        2
`define SSC_IRQ_WRITE_COLLISION_FLAG        3
`define SSC_IRQ_OVF         4
`define SSC_IRQ_W           5
// reset values
`define SSC_RST_STATUS      8'h00
`define SSC_RST_CTRL1       8'h00
`define SSC_RST_INT_MASK    5'h00
// mode codes
`define SSC_MODE_SPI_H0     4'h0
`define SSC_MODE_SPI_H3     4'h3
`define SSC_MODE_SPI_C_SS   4'h4
`define SSC_MODE_SPI_C      4'h5
`define SSC_MODE_I2C_C7     4'h6
`define SSC_MODE_I2C_C10    4'h7
`define SSC_MODE_I2C_H      4'h8
`define SSC_MODE_SPI_HA     4'hA
`define SSC_MODE_I2C_FW     4'hB
`define SSC_MODE_I2C_C7_SP  4'hE
`define SSC_MODE_I2C_C10_SP 4'hF
// shift counts
`define SSC_BIT_LAST        4'h7
`define SSC_BIT_ACK         4'h8
`endif

// *** rtl/ssc_top.v ***
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
// Summary of operation
// R1 - ten-bit client flags needed own-address reload
// R2 - i2c transmit: full until byte sent
// R3 - receive: full until software reads buffer
// R4 - i2c receive full ignores ack, stop
// R5 - start/stop flags cleared on reset, disable
// R6 - client direction bit from last address match
// R7 - active when busy or any host sequence
// R8 - host direction bit shows transmit progress
// R9 - spi: write while shifting sets collision
// R10 - i2c host: write when bus unready collides
// R11 - i2c client: write while transmitting collides
// R12 - receive: byte into full buffer overflows
// R13 - overflow, collision ignored in stated modes
// R14 - enable connects pins, else general i/o
// R15 - spi clock idle level from polarity
// R16 - i2c client: release bit stretches clock
// R17 - codes 1111/1110 client with start/stop irq
// R18 - hardware set beats software clear
module ssc_top (
  CLK,
  RESETN,
  ADDR,
  WDATA,
  WR,
  RD,
  RDATA,
  IRQ,
  SCK_IN,
  SDI,
  SS_N,
  SDO,
  SDO_OE,
  SCK_OUT,
  SCK_OE,
  SDA_IN,
  SCL_IN,
  SDA_OUT,
  SDA_OE,
  SCL_OUT,
  SCL_OE,
  PORT_ENABLE,
  ADDR_MATCH,
  ADDR_RW,
  NACK_SEEN,
  UA_SET,
  UA_CLEAR,
  BUS_READY,
  START_EN,
  RSTART_EN,
  STOP_EN,
  RECV_EN,
  ACK_EN,
  ACTIVE
);
`include "ssc_defines.vh"
  input                       CLK;
  input                       RESETN;
  input  [`SSC_ADDR_W-1:0]    ADDR;
  input  [7:0]                WDATA;
  input                       WR;
  input                       RD;
  output [7:0]                RDATA;
  output                      IRQ;
  input                       SCK_IN;
  input                       SDI;
  input                       SS_N;
  output                      SDO;
  output                      SDO_OE;
  output                      SCK_OUT;
  output                      SCK_OE;
  input                       SDA_IN;
  input                       SCL_IN;
  output                      SDA_OUT;
  output                      SDA_OE;
  output                      SCL_OUT;
  output                      SCL_OE;
  output                      PORT_ENABLE;
  input                       ADDR_MATCH;
  input                       ADDR_RW;
  input                       NACK_SEEN;
  input                       UA_SET;
  input                       UA_CLEAR;
  input                       BUS_READY;
  input                       START_EN;
  input                       RSTART_EN;
  input                       STOP_EN;
  input                       RECV_EN;
  input                       ACK_EN;
  output                      ACTIVE;

  // one-hot link states
  localparam ST_IDLE = 3'b001;
  localparam ST_SPI  = 3'b010;
  localparam ST_I2C  = 3'b100;

  ////////////////////////////////////////////////////////////////////////////
  // mode decode helpers

  function is_spi;
    input [3:0] m;
    begin
      is_spi = (m <= `SSC_MODE_SPI_C) || (m == `SSC_MODE_SPI_HA);
    end
  endfunction

  function is_spi_host;
    input [3:0] m;
    begin
      is_spi_host = (m <= `SSC_MODE_SPI_H3) || (m == `SSC_MODE_SPI_HA);
    end
  endfunction

  function is_i2c_client;
    input [3:0] m;
    begin
      is_i2c_client = (m == `SSC_MODE_I2C_C7) || (m == `SSC_MODE_I2C_C10) ||
                      (m == `SSC_MODE_I2C_C7_SP) || (m == `SSC_MODE_I2C_C10_SP);
    end
  endfunction

  function is_ten_bit;
    input [3:0] m;
    begin
      is_ten_bit = (m == `SSC_MODE_I2C_C10) || (m == `SSC_MODE_I2C_C10_SP);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  reg  [2:0]  pin_meta_reg;
  reg  [2:0]  pin_sync_reg;
  reg  [2:0]  pin_last_reg;
  reg  [1:0]  bus_meta_reg;
  reg  [1:0]  bus_sync_reg;
  reg  [1:0]  bus_last_reg;
  reg  [7:0]  ctrl_reg;
  reg  [7:0]  ctrl_next;
  reg  [7:0]  stat_reg;
  reg  [7:0]  stat_next;
  reg  [4:0]  int_stat_reg;
  reg  [4:0]  int_mask_reg;
  reg  [7:0]  rdata_reg;
  reg  [7:0]  shift_reg;
  reg  [7:0]  rx_buf_reg;
  reg  [3:0]  bit_cnt_reg;
  reg         tx_busy_reg;
  reg         sda_bit_reg;
  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [7:0]  rd_mux;

  wire [3:0]  mode       = ctrl_reg[`SSC_C1_MODE_HI:`SSC_C1_MODE_LO];
  wire        enable     = ctrl_reg[`SSC_C1_EN];
  wire        clock_polarity_release        = ctrl_reg[`SSC_C1_CKP];
  wire        cke        = stat_reg[`SSC_ST_CKE];
  wire        bf         = stat_reg[`SSC_ST_BF];
  wire        mode_spi   = is_spi(mode);
  wire        mode_spih  = is_spi_host(mode);
  wire        mode_i2cc  = is_i2c_client(mode);
  wire        mode_i2ch  = (mode == `SSC_MODE_I2C_H) || (mode == `SSC_MODE_I2C_FW);
  wire        sck_s      = pin_sync_reg[0];
  wire        sdi_s      = pin_sync_reg[1];
  wire        ss_n_s     = pin_sync_reg[2];
  wire        sda_s      = bus_sync_reg[0];
  wire        scl_s      = bus_sync_reg[1];
  wire        sck_rise   = sck_s & ~pin_last_reg[0];
  wire        sck_fall   = ~sck_s & pin_last_reg[0];
  wire        scl_rise   = scl_s & ~bus_last_reg[1];
  wire        scl_fall   = ~scl_s & bus_last_reg[1];
  wire        sda_last_fall = ~sda_s & bus_last_reg[0];
  wire        i2c_start  = sda_last_fall & scl_s & bus_last_reg[1];
  wire        i2c_stop   = sda_s & ~bus_last_reg[0] & scl_s & bus_last_reg[1];
  wire        ss_ok      = (mode != `SSC_MODE_SPI_C_SS) | ~ss_n_s;
  // leading edge leaves idle; with cke set data is sampled there
  wire        sck_lead   = clock_polarity_release ? sck_fall : sck_rise;
  wire        sck_trail  = clock_polarity_release ? sck_rise : sck_fall;
  wire        spi_sample = (state_reg == ST_SPI) & ss_ok & (cke ? sck_lead : sck_trail);
  wire        i2c_sample = (state_reg == ST_I2C) & scl_rise;
  wire        i2c_client_tx = mode_i2cc & stat_reg[`SSC_ST_RW];
  wire        host_seq   = START_EN | RSTART_EN | STOP_EN | RECV_EN | ACK_EN;
  wire        wr_ctrl    = WR & (ADDR == `SSC_ADDR_CTRL1);
  wire        wr_stat    = WR & (ADDR == `SSC_ADDR_STATUS);
  wire        wr_data    = WR & (ADDR == `SSC_ADDR_DATA);
  wire        wr_istat   = WR & (ADDR == `SSC_ADDR_INT_STAT);
  wire        wr_imask   = WR & (ADDR == `SSC_ADDR_INT_MASK);
  wire        rd_data    = RD & (ADDR == `SSC_ADDR_DATA);
  // data byte completes on the eighth sample; the ninth (ack) bit never counts
  wire        byte_done  = (spi_sample | i2c_sample) & (bit_cnt_reg == `SSC_BIT_LAST); // R4
  // spi is full duplex, so every spi byte counts as received
  wire        rx_ctx     = mode_spi | (mode_i2cc & ~stat_reg[`SSC_ST_RW]) | (mode_i2ch & RECV_EN);
  wire        i2c_tx_ctx = i2c_client_tx | (mode_i2ch & ~RECV_EN);
  wire        ev_start   = enable & ~mode_spi & i2c_start;
  wire        ev_stop    = enable & ~mode_spi & i2c_stop;
  reg         ev_write_collision_flag;
  reg         ev_ovf;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage feeds only the second

  always @(posedge CLK)
  begin
    if (!RESETN)
    begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
      pin_last_reg <= 3'h0;
      bus_meta_reg <= 2'h3;
      bus_sync_reg <= 2'h3;
      bus_last_reg <= 2'h3;
    end
    else
    begin
      pin_meta_reg <= {SS_N, SDI, SCK_IN};
      pin_sync_reg <= pin_meta_reg;
      pin_last_reg <= pin_sync_reg;
      bus_meta_reg <= {SCL_IN, SDA_IN};
      bus_sync_reg <= bus_meta_reg;
      bus_last_reg <= bus_sync_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link state: which shifter personality is live

  always @*
  begin
    state_next = ST_IDLE;
    case (state_reg)
      ST_IDLE, ST_SPI, ST_I2C:
      begin
        if (!enable)
          state_next = ST_IDLE; // R14
        else if (mode_spi)
          state_next = ST_SPI;
        else
          state_next = ST_I2C;
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // collision and overflow detection

  always @*
  begin
    ev_write_collision_flag = 1'b0;
    ev_ovf  = 1'b0;
    if (enable && wr_data)
    begin
      if (mode_spi)
        ev_write_collision_flag = tx_busy_reg | (bit_cnt_reg != 4'h0); // R9
      else if (mode_i2ch && !RECV_EN)
        ev_write_collision_flag = ~BUS_READY | tx_busy_reg | host_seq; // R10
      else if (i2c_client_tx)
        ev_write_collision_flag = tx_busy_reg; // R11
    end
    // host transmit never overflows: each transfer is started by software
    if (byte_done && bf && rx_ctx && !mode_spih && !(mode_i2ch && !RECV_EN))
      ev_ovf = 1'b1; // R12 R13
  end

  ////////////////////////////////////////////////////////////////////////////
  // control one: writable, hardware sets win over a software clear

  always @*
  begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl)
      ctrl_next = WDATA;
    if (ev_write_collision_flag)
      ctrl_next[`SSC_C1_WRITE_COLLISION_FLAG] = 1'b1; // R18 R11
    if (ev_ovf)
      ctrl_next[`SSC_C1_OVF] = 1'b1; // R18 R12
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags

  always @*
  begin
    stat_next = stat_reg;
    if (wr_stat)
    begin
      stat_next[`SSC_ST_SMP] = WDATA[`SSC_ST_SMP];
      stat_next[`SSC_ST_CKE] = WDATA[`SSC_ST_CKE];
    end
    // start and stop record only whichever came last
    if (ev_start)
    begin
      stat_next[`SSC_ST_START] = 1'b1;
      stat_next[`SSC_ST_STOP]  = 1'b0;
    end
    if (ev_stop)
    begin
      stat_next[`SSC_ST_STOP]  = 1'b1;
      stat_next[`SSC_ST_START] = 1'b0;
    end
    if (!enable)
    begin
      stat_next[`SSC_ST_START] = 1'b0; // R5
      stat_next[`SSC_ST_STOP]  = 1'b0; // R5
    end
    // direction bit: client latches address, host reports transmit
    if (mode_i2cc)
    begin
      if (ev_start || ev_stop || NACK_SEEN)
        stat_next[`SSC_ST_RW] = 1'b0; // R6
      if (ADDR_MATCH)
        stat_next[`SSC_ST_RW] = ADDR_RW; // R6
    end
    else if (mode_i2ch)
      stat_next[`SSC_ST_RW] = tx_busy_reg; // R8
    else
      stat_next[`SSC_ST_RW] = 1'b0;
    // address update needed only in ten-bit client modes
    if (!is_ten_bit(mode))
      stat_next[`SSC_ST_UA] = 1'b0;
    else if (UA_SET)
      stat_next[`SSC_ST_UA] = 1'b1; // R1
    else if (UA_CLEAR)
      stat_next[`SSC_ST_UA] = 1'b0; // R1
    // buffer full: receive side clears on read, transmit side on send
    if (rx_ctx && rd_data)
      stat_next[`SSC_ST_BF] = 1'b0; // R3
    if (i2c_tx_ctx && byte_done)
      stat_next[`SSC_ST_BF] = 1'b0; // R2
    if (i2c_tx_ctx && wr_data && !ev_write_collision_flag && enable)
      stat_next[`SSC_ST_BF] = 1'b1; // R2
    if (rx_ctx && byte_done)
      stat_next[`SSC_ST_BF] = 1'b1; // R3
    stat_next[`SSC_ST_DA] = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register updates

  always @(posedge CLK)
  begin
    if (!RESETN)
    begin
      ctrl_reg  <= `SSC_RST_CTRL1;
      stat_reg  <= `SSC_RST_STATUS;
      state_reg <= ST_IDLE;
    end
    else
    begin
      ctrl_reg  <= ctrl_next;
      stat_reg  <= stat_next;
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shifter: shared by spi full duplex and i2c client and host byte transfer

  always @(posedge CLK)
  begin
    if (!RESETN)
    begin
      shift_reg   <= 8'h00;
      rx_buf_reg  <= 8'h00;
      bit_cnt_reg <= 4'h0;
      tx_busy_reg <= 1'b0;
      sda_bit_reg <= 1'b1;
    end
    else if (state_reg == ST_IDLE)
    begin
      bit_cnt_reg <= 4'h0;
      tx_busy_reg <= 1'b0;
      sda_bit_reg <= 1'b1;
    end
    else
    begin
      // a colliding write is dropped so the byte in flight is not corrupted
      if (wr_data && !ev_write_collision_flag)
      begin
        shift_reg   <= WDATA;
        tx_busy_reg <= 1'b1;
      end
      else if (spi_sample || i2c_sample)
      begin
        if (bit_cnt_reg == `SSC_BIT_ACK)
          bit_cnt_reg <= 4'h0; // R4
        else
        begin
          shift_reg <= {shift_reg[6:0], (state_reg == ST_SPI) ? sdi_s : sda_s};
          if (bit_cnt_reg == `SSC_BIT_LAST)
          begin
            // rx data must not see the overwrite when the buffer was full
            if (!bf || !rx_ctx)
              rx_buf_reg <= {shift_reg[6:0], (state_reg == ST_SPI) ? sdi_s : sda_s};
            tx_busy_reg <= 1'b0;
            bit_cnt_reg <= (state_reg == ST_SPI) ? 4'h0 : `SSC_BIT_ACK;
          end
          else
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
      end
      if ((state_reg == ST_I2C) && i2c_start)
        bit_cnt_reg <= 4'h0;
      // i2c data changes only while the clock is low
      if ((state_reg == ST_I2C) && scl_fall)
        sda_bit_reg <= ~(i2c_client_tx & tx_busy_reg & (bit_cnt_reg < `SSC_BIT_ACK)) |
                       shift_reg[7];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status (write one to clear, set wins) and mask

  always @(posedge CLK)
  begin
    if (!RESETN)
    begin
      int_stat_reg <= 5'h00;
      int_mask_reg <= `SSC_RST_INT_MASK;
    end
    else
    begin
      int_stat_reg <= (int_stat_reg & ~(wr_istat ? WDATA[`SSC_IRQ_W-1:0] : 5'h00)) |
                      {ev_ovf, ev_write_collision_flag,
                       ev_stop & (mode == `SSC_MODE_I2C_C7_SP || mode == `SSC_MODE_I2C_C10_SP),
                       ev_start & (mode == `SSC_MODE_I2C_C7_SP || mode == `SSC_MODE_I2C_C10_SP),
                       byte_done}; // R17 R18
      if (wr_imask)
        int_mask_reg <= WDATA[`SSC_IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: data one cycle after the strobe, unmapped reads zero

  always @*
  begin
    rd_mux = 8'h00;
    case (ADDR)
      `SSC_ADDR_STATUS:   rd_mux = stat_reg;
      `SSC_ADDR_CTRL1:    rd_mux = ctrl_reg;
      `SSC_ADDR_DATA:     rd_mux = rx_buf_reg;
      `SSC_ADDR_INT_STAT: rd_mux = {3'h0, int_stat_reg};
      `SSC_ADDR_INT_MASK: rd_mux = {3'h0, int_mask_reg};
      default:            rd_mux = 8'h00;
    endcase
  end

  always @(posedge CLK)
  begin
    if (!RESETN)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= RD ? rd_mux : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive; no baud generator, so the host clock rests at idle

  assign RDATA       = rdata_reg;
  assign IRQ         = |(int_stat_reg & int_mask_reg);
  assign PORT_ENABLE = enable; // R14
  assign SDO         = shift_reg[7];
  assign SDO_OE      = (state_reg == ST_SPI) & ss_ok; // R14
  assign SCK_OUT     = clock_polarity_release; // R15
  assign SCK_OE      = (state_reg == ST_SPI) & mode_spih; // R15
  assign SDA_OUT     = 1'b0;
  assign SDA_OE      = (state_reg == ST_I2C) & ~sda_bit_reg;
  assign SCL_OUT     = 1'b0;
  assign SCL_OE      = (state_reg == ST_I2C) & mode_i2cc & ~clock_polarity_release; // R16
  assign ACTIVE      = (mode_i2ch & stat_reg[`SSC_ST_RW]) | host_seq; // R7

endmodule

// *** bench/ssc_props.sv ***
`timescale 1ns/100ps
`include "ssc_defines.vh"
////////////////////////////////////////////////////////////////////////////////
module ssc_props (
  input logic                   CLK,
  input logic                   RESETN,
  input logic [`SSC_ADDR_W-1:0] ADDR,
  input logic [7:0]             WDATA,
  input logic                   WR,
  input logic                   RD,
  input logic [7:0]             RDATA,
  input logic                   IRQ,
  input logic                   SDO_OE,
  input logic                   SCK_OUT,
  input logic                   SCK_OE,
  input logic                   SDA_OE,
  input logic                   SCL_OE,
  input logic                   PORT_ENABLE,
  input logic                   START_EN,
  input logic                   RSTART_EN,
  input logic                   STOP_EN,
  input logic                   RECV_EN,
  input logic                   ACK_EN,
  input logic                   ACTIVE
);
  logic [7:0] ctrl_reg;
  logic [4:0] mask_reg;
  logic       hold_cond;

  // shadows rebuilt from software writes; hardware-set flags are not needed here
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      ctrl_reg <= 8'h00;
      mask_reg <= 5'h00;
    end
    else if (WR && ADDR == `SSC_ADDR_CTRL1)
      ctrl_reg <= WDATA;
    else if (WR && ADDR == `SSC_ADDR_INT_MASK)
      mask_reg <= WDATA[4:0];
  end

  // client modes with the release bit low must stretch the clock
  assign hold_cond = ctrl_reg[5] && !ctrl_reg[4] && (ctrl_reg[3:0] inside {4'h6, 4'h7, 4'hE, 4'hF});

  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);

  sequence s_hold;
    hold_cond ##1 hold_cond;
  endsequence
  sequence s_off;
    !PORT_ENABLE ##1 !PORT_ENABLE;
  endsequence
  sequence s_stat_rd_off;
    !PORT_ENABLE ##1 (RD && ADDR == `SSC_ADDR_STATUS && !PORT_ENABLE);
  endsequence

  a_rdata_one_cycle: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data not zero outside the answer cycle");
  a_enable_follows: assert property (WR && ADDR == `SSC_ADDR_CTRL1 |=> PORT_ENABLE == $past(WDATA[5]))
    else $error("port enable does not follow control write");
  a_sck_idle_level: assert property (WR && ADDR == `SSC_ADDR_CTRL1 |=> SCK_OUT == $past(WDATA[4]))
    else $error("clock idle level does not follow polarity bit");
  a_pins_released: assert property (s_off |-> !(SDO_OE || SCK_OE || SDA_OE || SCL_OE))
    else $error("pin driven while port disabled");
  a_active_any_seq: assert property ((START_EN || RSTART_EN || STOP_EN || RECV_EN || ACK_EN) |-> ACTIVE)
    else $error("sequence bit set but port not active");
  a_clock_stretch: assert property (s_hold |-> SCL_OE)
    else $error("client clock not held low with release bit clear");
  a_flags_cleared_off: assert property (s_stat_rd_off |=> RDATA[4:3] == 2'b00)
    else $error("start or stop flag set while disabled");
  a_ctrl_readback: assert property (RD && ADDR == `SSC_ADDR_CTRL1 |=> RDATA[5:0] == $past(ctrl_reg[5:0]))
    else $error("control readback differs from written value");
  a_irq_masked: assert property ((mask_reg == 5'h00) [*2] |-> !IRQ)
    else $error("interrupt raised with all sources masked");
endmodule

bind ssc_top ssc_props u_ssc_props (
  .CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ),
  .SDO_OE(SDO_OE), .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE), .SDA_OE(SDA_OE), .SCL_OE(SCL_OE),
  .PORT_ENABLE(PORT_ENABLE), .START_EN(START_EN), .RSTART_EN(RSTART_EN), .STOP_EN(STOP_EN),
  .RECV_EN(RECV_EN), .ACK_EN(ACK_EN), .ACTIVE(ACTIVE)
);

// *** bench/ssc_peer.sv ***
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// far-side peer: spi host making a 400 ns link clock, i2c host making start and stop
module ssc_peer (
  output logic sck,
  output logic sdi,
  output logic ss_n,
  output logic sda_rel,
  output logic scl_rel
);
  initial
  begin
    sck = 1'b0;
    sdi = 1'b0;
    ss_n = 1'b1;
    sda_rel = 1'b1;
    scl_rel = 1'b1;
  end

  // msb first, data set well before the trailing edge; clock stands idle low after the frame
  task automatic spi_bits(input logic [7:0] d, input int n);
    for (int i = 0; i < n; i++)
    begin
      sdi = d[7-i];
      #100 sck = 1'b1;
      #200 sck = 1'b0;
      #100;
    end
    sdi = ~sdi;
  endtask

  task automatic i2c_start();
    scl_rel = 1'b1;
    sda_rel = 1'b1;
    #200 sda_rel = 1'b0;
    #200 scl_rel = 1'b0;
    #200;
  endtask

  task automatic i2c_stop();
    sda_rel = 1'b0;
    #200 scl_rel = 1'b1;
    #200 sda_rel = 1'b1;
    #200;
  endtask
endmodule

// *** bench/ssc_top_tb_top.sv ***
`timescale 1ns/100ps
`include "ssc_defines.vh"
////////////////////////////////////////////////////////////////////////////////
module ssc_top_tb_top;
  logic        clk, resetn, wr, rd, bus_ready, addr_rw;
  logic [11:0] addr;
  logic [7:0]  wdata;
  logic [4:0]  hs;
  logic [3:0]  ev;
  logic [3:0]  m;
  wire  [7:0]  rdata;
  wire         irq, sdo, sdo_oe, sck_out, sck_oe, sda_out, sda_oe, scl_out, scl_oe, port_en, active;
  wire         sck, sdi, ss_n, sda_rel, scl_rel;
  int          n_fail, checks;

  // open-drain lines: pulled up, low while either party pulls
  wire sda_w = sda_rel && !sda_oe;
  wire scl_w = scl_rel && !scl_oe;

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ssc_top u_ssc_top (
    .CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq),
    .SCK_IN(sck), .SDI(sdi), .SS_N(ss_n), .SDO(sdo), .SDO_OE(sdo_oe), .SCK_OUT(sck_out), .SCK_OE(sck_oe),
    .SDA_IN(sda_w), .SCL_IN(scl_w), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .SCL_OUT(scl_out), .SCL_OE(scl_oe),
    .PORT_ENABLE(port_en), .ADDR_MATCH(ev[0]), .ADDR_RW(addr_rw), .NACK_SEEN(ev[1]), .UA_SET(ev[2]),
    .UA_CLEAR(ev[3]), .BUS_READY(bus_ready), .START_EN(hs[0]), .RSTART_EN(hs[1]), .STOP_EN(hs[2]),
    .RECV_EN(hs[3]), .ACK_EN(hs[4]), .ACTIVE(active)
  );

  ssc_peer u_ssc_peer (.sck(sck), .sdi(sdi), .ss_n(ss_n), .sda_rel(sda_rel), .scl_rel(scl_rel));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // ends one step past the edge that takes the write, so outputs have settled
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] msk, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata & msk, exp);
  endtask

  task automatic fire(input logic [3:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 4'h0;
  endtask

  // link edges pass two sync flops before they count
  task automatic settle();
    repeat (8) @(posedge clk);
    #1;
  endtask

  task automatic summarize();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    #200_000;
    n_fail++;
    summarize();
  end

  initial
  begin
    resetn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 12'h000;
    wdata = 8'h00;
    hs = 5'h00;
    ev = 4'h0;
    bus_ready = 1'b0;
    addr_rw = 1'b1;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    rd_chk(`SSC_ADDR_STATUS, 8'hFF, 8'h00);
    rd_chk(`SSC_ADDR_CTRL1, 8'hFF, 8'h00);
    rd_chk(12'h000, 8'hFF, 8'h00);
    // each host sequence bit alone marks the port busy
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk);
      hs <= 5'(1 << i);
      @(posedge clk);
      #1 chk({7'h0, active}, 8'h01);
    end
    @(posedge clk);
    hs <= 5'h00;
    // spi client, idle-low clock
    wr_reg(`SSC_ADDR_CTRL1, 8'h35);
    chk({7'h0, sck_out}, 8'h01);
    wr_reg(`SSC_ADDR_CTRL1, 8'h25);
    chk({7'h0, sck_out}, 8'h00);
    chk({7'h0, port_en}, 8'h01);
    chk({6'h0, sdo_oe, sck_oe}, 8'h02);
    wr_reg(`SSC_ADDR_INT_MASK, 8'h11);
    u_ssc_peer.spi_bits(8'hA5, 8);
    settle();
    rd_chk(`SSC_ADDR_STATUS, 8'h01, 8'h01);
    chk({7'h0, irq}, 8'h01);
    rd_chk(`SSC_ADDR_DATA, 8'hFF, 8'hA5);
    rd_chk(`SSC_ADDR_STATUS, 8'h01, 8'h00);
    wr_reg(`SSC_ADDR_INT_STAT, 8'h1F);
    chk({7'h0, irq}, 8'h00);
    // second byte lands on an unread one: old byte kept, overflow raised
    u_ssc_peer.spi_bits(8'h5A, 8);
    u_ssc_peer.spi_bits(8'hC3, 8);
    settle();
    rd_chk(`SSC_ADDR_CTRL1, 8'hFF, 8'h65);
    rd_chk(`SSC_ADDR_DATA, 8'hFF, 8'h5A);
    wr_reg(`SSC_ADDR_CTRL1, 8'h25);
    rd_chk(`SSC_ADDR_CTRL1, 8'hFF, 8'h25);
    wr_reg(`SSC_ADDR_INT_STAT, 8'h1F);
    // a write in mid-shift collides
    wr_reg(`SSC_ADDR_DATA, 8'hC3);
    @(posedge clk);
    #1 chk({7'h0, sdo}, 8'h01);
    u_ssc_peer.spi_bits(8'h00, 4);
    settle();
    wr_reg(`SSC_ADDR_DATA, 8'h0F);
    rd_chk(`SSC_ADDR_CTRL1, 8'hFF, 8'hA5);
    u_ssc_peer.spi_bits(8'h00, 4);
    settle();
    rd_chk(`SSC_ADDR_DATA, 8'hFF, 8'h00);
    // slave-select client while deselected: data pin let go
    wr_reg(`SSC_ADDR_CTRL1, 8'h24);
    chk({6'h0, sdo_oe, sck_oe}, 8'h00);
    // i2c client codes with start and stop interrupts
    wr_reg(`SSC_ADDR_INT_MASK, 8'h06);
    for (int k = 0; k < 2; k++)
    begin
      m = k[0] ? 4'hF : 4'hE;
      wr_reg(`SSC_ADDR_CTRL1, {4'h2, m});
      settle();
      chk({7'h0, scl_oe}, 8'h01);
      chk({6'h0, sda_out, scl_out}, 8'h00);
      wr_reg(`SSC_ADDR_CTRL1, {4'h3, m});
      settle();
      chk({7'h0, scl_oe}, 8'h00);
      u_ssc_peer.i2c_start();
      settle();
      rd_chk(`SSC_ADDR_STATUS, 8'h18, 8'h08);
      chk({7'h0, irq}, 8'h01);
      u_ssc_peer.i2c_stop();
      settle();
      rd_chk(`SSC_ADDR_STATUS, 8'h18, 8'h10);
      fire(4'h1);
      rd_chk(`SSC_ADDR_STATUS, 8'h04, 8'h04);
      fire(4'h2);
      rd_chk(`SSC_ADDR_STATUS, 8'h04, 8'h00);
      fire(4'h4);
      rd_chk(`SSC_ADDR_STATUS, 8'h02, {6'h00, k[0], 1'b0});
      fire(4'h8);
      rd_chk(`SSC_ADDR_STATUS, 8'h02, 8'h00);
      wr_reg(`SSC_ADDR_CTRL1, {4'h1, m});
      rd_chk(`SSC_ADDR_STATUS, 8'h18, 8'h00);
      wr_reg(`SSC_ADDR_INT_STAT, 8'h1F);
    end
    // plain seven-bit client: start flag is kept but raises no interrupt
    wr_reg(`SSC_ADDR_CTRL1, 8'h36);
    u_ssc_peer.i2c_start();
    settle();
    rd_chk(`SSC_ADDR_STATUS, 8'h18, 8'h08);
    chk({7'h0, irq}, 8'h00);
    u_ssc_peer.i2c_stop();
    settle();
    // i2c host: no transmit start while the bus is not ready
    wr_reg(`SSC_ADDR_CTRL1, 8'h28);
    wr_reg(`SSC_ADDR_DATA, 8'h55);
    rd_chk(`SSC_ADDR_CTRL1, 8'hFF, 8'hA8);
    wr_reg(`SSC_ADDR_CTRL1, 8'h28);
    @(posedge clk);
    bus_ready <= 1'b1;
    wr_reg(`SSC_ADDR_DATA, 8'h55);
    rd_chk(`SSC_ADDR_CTRL1, 8'hFF, 8'h28);
    rd_chk(`SSC_ADDR_STATUS, 8'h05, 8'h05);
    chk({7'h0, active}, 8'h01);
    summarize();
  end
endmodule
